/* File: verilog/frc_defines.vh */
// offsets, fields, reset values and timing counts of the fault relay block
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH

`define FRC_ADDR_W          8
`define FRC_CTRL            8'h00
`define FRC_STATUS          8'h04
`define FRC_IRQ_STAT        8'h08
`define FRC_IRQ_MASK        8'h0c
`define FRC_SYS_SEL         8'h10
`define FRC_PORT_SEL        8'h14
`define FRC_REL_OFS_CFG     5'h00
`define FRC_REL_OFS_LINK    5'h04
`define FRC_REL_OFS_ON      5'h08
`define FRC_REL_OFS_OFF     5'h0c
`define FRC_REL_OFS_RST     5'h10
`define FRC_REL_OFS_HOLD    5'h14

`define FRC_CTRL_APPLY      0
`define FRC_CFG_EN          0
`define FRC_CFG_TYPE_LO     1
`define FRC_CFG_TYPE_HI     3
`define FRC_CFG_SEL         4
`define FRC_CFG_LEVEL       5

`define FRC_TYPE_LEVEL      3'h0
`define FRC_TYPE_DRY        3'h1
`define FRC_TYPE_SUPPLY     3'h2
`define FRC_TYPE_LINK       3'h3
`define FRC_TYPE_PING       3'h4
`define FRC_TYPE_RING       3'h5

`define FRC_NUM_RELAY       2
`define FRC_NUM_PORT        10
`define FRC_NUM_EVT         13

`define FRC_EVT_COLD        0
`define FRC_EVT_WARM        1
`define FRC_EVT_SUP1        2
`define FRC_EVT_SUP2        3
`define FRC_EVT_AUTH        4
`define FRC_EVT_TSYNC       5
`define FRC_EVT_RELAY       6
`define FRC_EVT_RING        7
`define FRC_EVT_XCVR        8
`define FRC_EVT_SENSE1      9
`define FRC_EVT_SENSE2      10
`define FRC_EVT_LOOP        11
`define FRC_EVT_PORT        12

`define FRC_PIN_RST         4'hc
`define FRC_CLK_HZ          200000000
`define FRC_TICK_S          1
`define FRC_SEC_CYCLES      (`FRC_TICK_S * `FRC_CLK_HZ)

`endif

/* File: verilog/frc_fault_relay.v */
// fault relay controller with apb register file and event interrupt
//
// What this block does
// [RULE1] two relay outputs, open normally, closed while their fault is active
// [RULE2] each relay takes exactly one fault source type with own settings
// [RULE3] level mode: chosen sense input at chosen level closes relay, lamp on
// [RULE4] dry mode holds on and off periods, full 32-bit seconds each
// [RULE5] dry mode closes for on-period, then opens for off-period, repeating
// [RULE6] on 1 off 0 stays closed; on 0 off 1 stays open
// [RULE7] supply mode: chosen supply input lost closes relay, lamp on
// [RULE8] link mode: any masked port link down closes relay, lamp on
// [RULE9] ping mode closes relay, on reported failure opens for reset time
// [RULE10] after reset time closes again, monitoring paused for hold time
// [RULE11] ring mode: topology change indication closes relay, lamp on
// [RULE12] event selection kept as system group and port group
// [RULE13] system group flags for each listed system event
// [RULE14] port selection on link up, link down or both; default disabled
// [RULE15] per relay enable; relay settings take effect on apply strobe
// [RULE16] lamp lit while an enabled relay is closed by a detected fault
`timescale 1ns/1ps
`include "frc_defines.vh"

module frc_fault_relay #(
  parameter [31:0] SEC_CYCLES = `FRC_SEC_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire [1:0]  sense_input,
  input  wire [1:0]  supply_ok,
  input  wire [9:0]  link_up,
  input  wire        ring_change,
  input  wire [1:0]  ping_fail,
  input  wire        cold_start_evt,
  input  wire        warm_start_evt,
  input  wire        auth_fail_evt,
  input  wire        time_sync_fail_evt,
  input  wire        xcvr_fail_evt,
  input  wire        loop_evt,
  output wire [1:0]  relay_close,
  output reg         fault_lamp,
  output wire [1:0]  ping_monitor,
  output wire        irq
);

  localparam ST_IDLE      = 6'h01;
  localparam ST_DRY_ON    = 6'h02;
  localparam ST_DRY_OFF   = 6'h04;
  localparam ST_PING_MON  = 6'h08;
  localparam ST_PING_OFF  = 6'h10;
  localparam ST_PING_HOLD = 6'h20;

  // apb access strobes
  wire        wr_en;
  wire        setup;
  wire        apply;
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite;
  assign apply  = wr_en & (paddr == `FRC_CTRL)
                  & pwdata[`FRC_CTRL_APPLY]; //RULE15

  // pin inputs: three stages, change taken when stages two and three agree
  reg  [3:0]  pin_s1;
  reg  [3:0]  pin_s2;
  reg  [3:0]  pin_s3;
  reg  [3:0]  pin_filt;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1   <= `FRC_PIN_RST;
      pin_s2   <= `FRC_PIN_RST;
      pin_s3   <= `FRC_PIN_RST;
      pin_filt <= `FRC_PIN_RST;
    end else begin
      pin_s1 <= {supply_ok, sense_input};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_filt <= pin_s3;
      end
    end
  end
  wire [1:0]  sense_filt;
  wire [1:0]  supply_filt;
  assign sense_filt  = pin_filt[1:0];
  assign supply_filt = pin_filt[3:2];

  // one pulse per second
  reg  [31:0] sec_cnt;
  reg         sec_tick;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_cnt  <= 32'h0;
      sec_tick <= 1'b0;
    end else if (sec_cnt >= SEC_CYCLES - 32'h1) begin
      sec_cnt  <= 32'h0;
      sec_tick <= 1'b1;
    end else begin
      sec_cnt  <= sec_cnt + 32'h1;
      sec_tick <= 1'b0;
    end
  end

  // relay channels
  wire [31:0] rd_rel [0:1];
  wire [1:0]  rel_fault;
  wire [1:0]  rel_close;
  assign relay_close = rel_close;

  genvar gi;
  generate
    for (gi = 0; gi < `FRC_NUM_RELAY; gi = gi + 1) begin : g_rel
      wire        hit;
      reg  [5:0]  sh_cfg;
      reg  [9:0]  sh_link;
      reg  [31:0] sh_on;
      reg  [31:0] sh_off;
      reg  [31:0] sh_rst;
      reg  [31:0] sh_hold;
      reg  [5:0]  a_cfg;
      reg  [9:0]  a_link;
      reg  [31:0] a_on;
      reg  [31:0] a_off;
      reg  [31:0] a_rst;
      reg  [31:0] a_hold;
      reg  [5:0]  st;
      reg  [5:0]  next_st;
      reg  [31:0] cnt;
      reg         ring_seen;
      reg         cond;
      reg         close_r;
      reg  [31:0] per;
      reg  [31:0] rd;
      wire [2:0]  typ;
      wire        en;
      wire [32:0] cnt_inc;
      wire        done;

      assign hit = ({29'h0, paddr[7:5]} == gi + 1);
      assign typ = a_cfg[`FRC_CFG_TYPE_HI:`FRC_CFG_TYPE_LO]; //RULE2
      assign en  = a_cfg[`FRC_CFG_EN];

      // shadow settings written by software
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          sh_cfg  <= 6'h0;
          sh_link <= 10'h0;
          sh_on   <= 32'h0;
          sh_off  <= 32'h0;
          sh_rst  <= 32'h0;
          sh_hold <= 32'h0;
        end else if (wr_en && hit) begin
          case (paddr[4:0])
            `FRC_REL_OFS_CFG:  sh_cfg  <= pwdata[5:0];
            `FRC_REL_OFS_LINK: sh_link <= pwdata[9:0]; //RULE8
            `FRC_REL_OFS_ON:   sh_on   <= pwdata; //RULE4
            `FRC_REL_OFS_OFF:  sh_off  <= pwdata; //RULE4
            `FRC_REL_OFS_RST:  sh_rst  <= pwdata;
            `FRC_REL_OFS_HOLD: sh_hold <= pwdata;
            default: sh_cfg <= sh_cfg;
          endcase
        end
      end

      always @* begin
        case (paddr[4:0])
          `FRC_REL_OFS_CFG:  rd = {26'h0, sh_cfg};
          `FRC_REL_OFS_LINK: rd = {22'h0, sh_link};
          `FRC_REL_OFS_ON:   rd = sh_on;
          `FRC_REL_OFS_OFF:  rd = sh_off;
          `FRC_REL_OFS_RST:  rd = sh_rst;
          `FRC_REL_OFS_HOLD: rd = sh_hold;
          default:           rd = 32'h0;
        endcase
      end
      assign rd_rel[gi] = rd;

      // period of the running timer and its expiry
      always @* begin
        case (st)
          ST_DRY_ON:   per = a_on;
          ST_DRY_OFF:  per = a_off;
          ST_PING_OFF: per = a_rst;
          default:     per = a_hold;
        endcase
      end
      assign cnt_inc = {1'b0, cnt} + 33'h1;
      assign done = (per == 32'h0) | (sec_tick & (cnt_inc >= {1'b0, per}));

      always @* begin
        next_st = st;
        case (st)
          ST_IDLE: next_st = ST_IDLE;
          ST_DRY_ON: begin
            if ((a_off != 32'h0)
                && ((a_on == 32'h0) || done)) begin //RULE5 RULE6
              next_st = ST_DRY_OFF;
            end
          end
          ST_DRY_OFF: begin
            if ((a_on != 32'h0) && done) begin //RULE5 RULE6
              next_st = ST_DRY_ON;
            end
          end
          ST_PING_MON: begin
            if (ping_fail[gi]) begin //RULE9
              next_st = ST_PING_OFF;
            end
          end
          ST_PING_OFF: begin
            if (done) begin //RULE10
              next_st = ST_PING_HOLD;
            end
          end
          ST_PING_HOLD: begin
            if (done) begin //RULE10
              next_st = ST_PING_MON;
            end
          end
          default: next_st = ST_IDLE;
        endcase
      end

      // apply copies settings and restarts the mode
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          a_cfg     <= 6'h0;
          a_link    <= 10'h0;
          a_on      <= 32'h0;
          a_off     <= 32'h0;
          a_rst     <= 32'h0;
          a_hold    <= 32'h0;
          st        <= ST_IDLE;
          cnt       <= 32'h0;
          ring_seen <= 1'b0;
        end else if (apply) begin //RULE15
          a_cfg     <= sh_cfg;
          a_link    <= sh_link;
          a_on      <= sh_on;
          a_off     <= sh_off;
          a_rst     <= sh_rst;
          a_hold    <= sh_hold;
          cnt       <= 32'h0;
          ring_seen <= 1'b0;
          case (sh_cfg[`FRC_CFG_TYPE_HI:`FRC_CFG_TYPE_LO])
            `FRC_TYPE_DRY:  st <= ST_DRY_ON;
            `FRC_TYPE_PING: st <= ST_PING_MON; //RULE9
            default:        st <= ST_IDLE;
          endcase
        end else begin
          st <= next_st;
          if (next_st != st) begin
            cnt <= 32'h0;
          end else if (sec_tick) begin
            cnt <= cnt_inc[31:0];
          end
          if (ring_change && en && (typ == `FRC_TYPE_RING)) begin
            ring_seen <= 1'b1; //RULE11
          end
        end
      end

      always @* begin
        case (typ)
          `FRC_TYPE_LEVEL:
            cond = sense_filt[a_cfg[`FRC_CFG_SEL]]
                   == a_cfg[`FRC_CFG_LEVEL]; //RULE3
          `FRC_TYPE_DRY:
            cond = (st == ST_DRY_ON) && (a_on != 32'h0); //RULE5 RULE6
          `FRC_TYPE_SUPPLY:
            cond = ~supply_filt[a_cfg[`FRC_CFG_SEL]]; //RULE7
          `FRC_TYPE_LINK:
            cond = |(a_link & ~link_up); //RULE8
          `FRC_TYPE_PING:
            cond = (st == ST_PING_MON) || (st == ST_PING_HOLD); //RULE9 RULE10
          `FRC_TYPE_RING:
            cond = ring_seen; //RULE11
          default:
            cond = 1'b0;
        endcase
      end

      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          close_r <= 1'b0;
        end else begin
          close_r <= en & cond; //RULE1 RULE15
        end
      end
      assign rel_close[gi] = close_r;

      assign rel_fault[gi] = rel_close[gi] & (typ != `FRC_TYPE_DRY)
                             & (typ != `FRC_TYPE_PING);
      assign ping_monitor[gi] = en & (st == ST_PING_MON); //RULE10
    end
  endgenerate

  // lamp and event edges
  reg  [9:0]  link_prev;
  reg  [3:0]  pin_prev;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_lamp <= 1'b0;
      link_prev  <= 10'h0;
      pin_prev   <= `FRC_PIN_RST;
    end else begin
      fault_lamp <= |rel_fault; //RULE3 RULE7 RULE8 RULE11 RULE16
      link_prev  <= link_up;
      pin_prev   <= pin_filt;
    end
  end

  reg  [19:0] port_sel;
  wire [9:0]  port_hit;
  generate
    for (gi = 0; gi < `FRC_NUM_PORT; gi = gi + 1) begin : g_port
      assign port_hit[gi] =
        (port_sel[2*gi]   &  link_up[gi] & ~link_prev[gi]) | //RULE14
        (port_sel[2*gi+1] & ~link_up[gi] &  link_prev[gi]);  //RULE14
    end
  endgenerate

  wire [12:0] evt_raw;
  assign evt_raw[`FRC_EVT_COLD]   = cold_start_evt;
  assign evt_raw[`FRC_EVT_WARM]   = warm_start_evt;
  assign evt_raw[`FRC_EVT_SUP1]   = pin_prev[2] & ~pin_filt[2];
  assign evt_raw[`FRC_EVT_SUP2]   = pin_prev[3] & ~pin_filt[3];
  assign evt_raw[`FRC_EVT_AUTH]   = auth_fail_evt;
  assign evt_raw[`FRC_EVT_TSYNC]  = time_sync_fail_evt;
  assign evt_raw[`FRC_EVT_RELAY]  = (|rel_fault) & ~fault_lamp;
  assign evt_raw[`FRC_EVT_RING]   = ring_change;
  assign evt_raw[`FRC_EVT_XCVR]   = xcvr_fail_evt;
  assign evt_raw[`FRC_EVT_SENSE1] = pin_prev[0] ^ pin_filt[0];
  assign evt_raw[`FRC_EVT_SENSE2] = pin_prev[1] ^ pin_filt[1];
  assign evt_raw[`FRC_EVT_LOOP]   = loop_evt;
  assign evt_raw[`FRC_EVT_PORT]   = |port_hit; //RULE12

  // selection, sticky status and mask
  reg  [11:0] sys_sel;
  reg  [12:0] irq_stat;
  reg  [12:0] irq_mask;
  wire [12:0] evt_set;
  assign evt_set = evt_raw & {1'b1, sys_sel}; //RULE12 RULE13
  assign irq = |(irq_stat & irq_mask);

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_sel  <= 12'h0;
      port_sel <= 20'h0;
      irq_mask <= 13'h0;
      irq_stat <= 13'h0;
    end else begin
      if (wr_en && (paddr == `FRC_SYS_SEL)) begin
        sys_sel <= pwdata[11:0]; //RULE13
      end
      if (wr_en && (paddr == `FRC_PORT_SEL)) begin
        port_sel <= pwdata[19:0]; //RULE14
      end
      if (wr_en && (paddr == `FRC_IRQ_MASK)) begin
        irq_mask <= pwdata[12:0];
      end
      if (wr_en && (paddr == `FRC_IRQ_STAT)) begin
        irq_stat <= (irq_stat & ~pwdata[12:0]) | evt_set;
      end else begin
        irq_stat <= irq_stat | evt_set;
      end
    end
  end

  // read data and error latched in the setup cycle
  reg  [31:0] rd_mux;
  reg         rd_bad;
  always @* begin
    rd_mux = 32'h0;
    rd_bad = 1'b0;
    if (paddr[7:5] == 3'h1) begin
      rd_mux = rd_rel[0];
      rd_bad = paddr[4:0] > `FRC_REL_OFS_HOLD;
    end else if (paddr[7:5] == 3'h2) begin
      rd_mux = rd_rel[1];
      rd_bad = paddr[4:0] > `FRC_REL_OFS_HOLD;
    end else begin
      case (paddr)
        `FRC_CTRL:     rd_mux = 32'h0;
        `FRC_STATUS:   rd_mux = {25'h0, pin_filt, fault_lamp, rel_close};
        `FRC_IRQ_STAT: rd_mux = {19'h0, irq_stat};
        `FRC_IRQ_MASK: rd_mux = {19'h0, irq_mask};
        `FRC_SYS_SEL:  rd_mux = {20'h0, sys_sel};
        `FRC_PORT_SEL: rd_mux = {12'h0, port_sel};
        default:       rd_bad = 1'b1;
      endcase
    end
    if (paddr[1:0] != 2'h0) begin
      rd_bad = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= rd_bad ? 32'h0 : rd_mux;
      pslverr <= rd_bad;
    end
  end

endmodule // frc_fault_relay

/* File: bench/frc_ping_target.sv */
// ping target model powered through the relay contacts
`timescale 1ns/1ps
module frc_ping_target (
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire [1:0] relay_close,
  input  wire [1:0] ping_monitor,
  input  wire [1:0] hang_req,
  output reg  [1:0] ping_fail
);
  reg [1:0] dead;
  // a hung target answers no ping until its power is cycled
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dead      <= 2'h0;
      ping_fail <= 2'h0;
    end else begin
      dead      <= (dead | hang_req) & relay_close;
      ping_fail <= dead & ping_monitor & ~ping_fail;
    end
  end
endmodule // frc_ping_target

/* File: bench/frc_fault_relay_checker.sv */
// port checker for the fault relay controller
`timescale 1ns/1ps
module frc_fault_relay_checker (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  ping_fail,
  input wire logic [1:0]  relay_close,
  input wire logic        fault_lamp,
  input wire logic [1:0]  ping_monitor,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire mapped = paddr[1:0] == 2'h0 && (paddr < 8'h18 ||
    ((paddr[7:5] == 3'h1 || paddr[7:5] == 3'h2) && paddr[4:0] < 5'h18));

  reset_clear_a: assert property ($rose(rst_b) |->
    relay_close == 2'h0 && !fault_lamp && !irq) else $error("reset state");
  lamp_cause_a: assert property (relay_close == 2'h0 |=>
    !fault_lamp) else $error("lamp without relay");
  mon_closed_a: assert property (ping_monitor[0] &&
    $past(ping_monitor[0]) |-> relay_close[0]) else $error("monitor open");
  fail_opens_a: assert property (ping_monitor[0] && ping_fail[0] |=>
    !ping_monitor[0] ##1 !relay_close[0]) else $error("ping fail kept");
  err_decode_a: assert property (psel && !penable |=>
    pslverr == !$past(mapped)) else $error("bad decode");
  err_zero_a: assert property (psel && !penable ##1 pslverr |->
    prdata == 32'h0) else $error("error data");
  rd_hold_a: assert property (psel && penable |=>
    $stable(prdata) && $stable(pslverr)) else $error("read data moved");
  ready_high_a: assert property (pready) else $error("wait state");
  cover property (ping_monitor[0] && ping_fail[0]);
  cover property ($rose(fault_lamp));
  cover property ($rose(irq));
endmodule // frc_fault_relay_checker

bind frc_fault_relay frc_fault_relay_checker u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ping_fail(ping_fail), .relay_close(relay_close),
  .fault_lamp(fault_lamp), .ping_monitor(ping_monitor), .irq(irq));

/* File: bench/tb_top.sv */
// self-checking testbench for the fault relay controller
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, rst_b, psel, penable, pwrite, ring_change;
  logic        pready, pslverr, fault_lamp, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  sense_input, supply_ok, ping_fail, relay_close;
  logic [1:0]  ping_monitor, hang_req;
  logic [9:0]  link_up, msk;
  logic [5:0]  evt;
  int          n_mismatch, n_checks, n, k;
  int          ev_bit[6] = '{0, 1, 4, 5, 8, 11};
  logic [31:0] q_d[$], q_m[$];
  logic        q_e[$];
  wire  [3:0]  obs = {ping_monitor, relay_close};

  frc_fault_relay #(.SEC_CYCLES(32'd8)) dut (.core_clk(core_clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_input(sense_input), .supply_ok(supply_ok),
    .link_up(link_up), .ring_change(ring_change), .ping_fail(ping_fail),
    .cold_start_evt(evt[0]), .warm_start_evt(evt[1]),
    .auth_fail_evt(evt[2]), .time_sync_fail_evt(evt[3]),
    .xcvr_fail_evt(evt[4]), .loop_evt(evt[5]), .relay_close(relay_close),
    .fault_lamp(fault_lamp), .ping_monitor(ping_monitor), .irq(irq));
  frc_ping_target u_tgt (.core_clk(core_clk), .rst_b(rst_b),
    .relay_close(relay_close), .ping_monitor(ping_monitor),
    .hang_req(hang_req), .ping_fail(ping_fail));

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, m, input logic er);
    q_d.push_back(e & m); q_m.push_back(m); q_e.push_back(er);
    apb(1'b0, a, 32'h0);
  endtask
  task wt(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task st(input logic [1:0] r, input logic l);
    rd(8'h04, {29'h0, l, r}, 32'h7, 1'b0);
  endtask
  task cnt(input int i, input logic v, output int c);
    c = 0;
    while (obs[i] === v && c < 2000) begin
      @(posedge core_clk);
      c++;
    end
  endtask
  task pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge core_clk);
    evt <= 6'h0;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // read results are compared against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && q_d.size() > 0) begin
      chk(prdata & q_m.pop_front(), q_d.pop_front());
      chk({31'h0, pslverr}, {31'h0, q_e.pop_front()});
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; sense_input = 2'h0; supply_ok = 2'h3;
    link_up = 10'h3ff; ring_change = 1'b0; evt = 6'h0; hang_req = 2'h0;
    n_mismatch = 0; n_checks = 0;
    void'($urandom(91655));
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(8'h04, 32'h60, 32'h7f, 1'b0);
    rd(8'h14, 32'h0, 32'hfffff, 1'b0);
    rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
    foreach (ev_bit[i]) begin
      k = ev_bit[i];
      wr(8'h10, 32'h1 << k); wr(8'h0c, 32'h0); pulse(i); wt(2);
      chk(irq, 1'b0);
      rd(8'h08, 32'h1 << k, 32'h1fff, 1'b0);
      wr(8'h0c, 32'h1 << k); chk(irq, 1'b1);
      wr(8'h08, 32'h1 << k); chk(irq, 1'b0);
    end
    pulse(0); wt(2);
    rd(8'h08, 32'h0, 32'h1fff, 1'b0);
    wr(8'h14, 32'h2); link_up[0] <= 1'b0; wt(3);
    rd(8'h08, 32'h1000, 32'h1fff, 1'b0);
    wr(8'h08, 32'h1000); link_up[0] <= 1'b1; wt(3);
    rd(8'h08, 32'h0, 32'h1fff, 1'b0);
    wr(8'h14, 32'hc); link_up[1] <= 1'b0; wt(3);
    rd(8'h08, 32'h1000, 32'h1fff, 1'b0);
    wr(8'h08, 32'h1000); link_up[1] <= 1'b1; wt(3);
    rd(8'h08, 32'h1000, 32'h1fff, 1'b0);
    wr(8'h08, 32'h1000); wr(8'h14, 32'h0); wr(8'h10, 32'h6cc);
    sense_input <= 2'h1; wr(8'h20, 32'h21); wt(8);
    st(2'h0, 1'b0);
    rd(8'h20, 32'h21, 32'h3f, 1'b0);
    wr(8'h00, 32'h1); wt(8); st(2'h1, 1'b1);
    rd(8'h08, 32'h240, 32'h1fff, 1'b0);
    wr(8'h08, 32'h1fff);
    sense_input <= 2'h0; wt(8); st(2'h0, 1'b0);
    wr(8'h20, 32'h11); wr(8'h00, 32'h1); wt(8); st(2'h1, 1'b1);
    wr(8'h20, 32'h10); wr(8'h00, 32'h1); wt(8); st(2'h0, 1'b0);
    wr(8'h40, 32'h15); wr(8'h00, 32'h1); supply_ok <= 2'h1; wt(8);
    st(2'h2, 1'b1);
    supply_ok <= 2'h3; wt(8); st(2'h0, 1'b0);
    msk = 10'($urandom_range(1023, 1)); k = $urandom_range(9, 0);
    while (!msk[k]) k = $urandom_range(9, 0);
    wr(8'h40, 32'h07); wr(8'h44, {22'h0, msk}); wr(8'h00, 32'h1); wt(4);
    st(2'h0, 1'b0);
    link_up <= msk; wt(4); st(2'h0, 1'b0);
    link_up <= ~(10'h1 << k); wt(4); st(2'h2, 1'b1);
    link_up <= 10'h3ff;
    wr(8'h40, 32'h0b); wr(8'h00, 32'h1); wt(4); st(2'h0, 1'b0);
    ring_change <= 1'b1; @(posedge core_clk); ring_change <= 1'b0; wt(4);
    st(2'h2, 1'b1);
    supply_ok <= 2'h0; sense_input <= 2'h2; wt(8);
    rd(8'h08, 32'h6cc, 32'h1fff, 1'b0);
    wr(8'h08, 32'h1fff); supply_ok <= 2'h3; sense_input <= 2'h0;
    wr(8'h40, 32'h0); wr(8'h4c, 32'hffffffff);
    rd(8'h4c, 32'hffffffff, 32'hffffffff, 1'b0);
    wr(8'h28, 32'h1); wr(8'h2c, 32'h0); wr(8'h20, 32'h03); wr(8'h00, 32'h1);
    wt(40); st(2'h1, 1'b0);
    wr(8'h28, 32'h0); wr(8'h2c, 32'h1); wr(8'h00, 32'h1);
    wt(40); st(2'h0, 1'b0);
    wr(8'h28, 32'h2); wr(8'h00, 32'h1); wt(2);
    cnt(0, 1'b1, n); cnt(0, 1'b0, n); chk(n, 8);
    cnt(0, 1'b1, n); chk(n, 16);
    wr(8'h30, 32'h2); wr(8'h34, 32'h2); wr(8'h20, 32'h09); wr(8'h00, 32'h1);
    wt(4); chk(obs[2] & obs[0], 1'b1);
    hang_req[0] <= 1'b1; @(posedge core_clk); hang_req <= 2'h0;
    cnt(2, 1'b1, n); wt(1);
    cnt(0, 1'b0, n); chk(n >= 8 && n <= 16, 1'b1);
    cnt(2, 1'b0, n); chk(n >= 7 && n <= 16, 1'b1);
    wt(30); chk(obs[2] & obs[0], 1'b1);
    end_sim;
  end
endmodule // tb_top
